// >>> hw/adct_cfg.svh
`ifndef ADCT_CFG_SVH
`define ADCT_CFG_SVH
// Operation
// - each conversion runs a sample phase first, then one comparison step per result bit, ten in all.
// - every phase length is counted in half cpu periods, two units per clock cycle.
// - clock select and sample time select come from the upper four bits of the control register.
// - a conversion is sample, comparison and a transfer phase; done is signalled after the transfer ends.
// - clock select 00 gives samples of 120/140/200/400 units and totals of 388/436/532/724.
// - clock select 11 gives samples of 240/280/400/800 units and totals of 772/868/1060/1444.
// - clock select 10 gives samples of 480/560/800/1600 units and totals of 1540/1732/2116/2884.
// - comparison is 1120 units (sel 10) or 560 (sel 11) for sample select 01..11; transfer fills the rest.
// - the result is a 10-bit unsigned code from 0 to 3ff.
// - after the sample phase the sampled value is held and input changes have no effect.
// - the power-off bit switches the analog circuitry off while set.

// control register field positions
`define ADCT_STC_LSB 12
`define ADCT_CTC_LSB 14
`define ADCT_POWER_OFF_BIT 5
// timing unit: two units per cpu clock
`define ADCT_UNITS_PER_CLK 2
`define ADCT_RESULT_BITS 10
`define ADCT_RESULT_MAX 10'h3ff
`endif

// >>> hw/adct_pkg.sv
package adct_pkg;
  typedef enum logic [2:0] {
    ADCT_IDLE = 3'b000,
    ADCT_SAMPLE = 3'b001,
    ADCT_COMPARE = 3'b010,
    ADCT_XFER = 3'b011
  } adct_state_t;
  typedef logic [11:0] adct_units_t;
endpackage

// >>> hw/adct_seq.sv
`timescale 1ns/1ps
`include "adct_cfg.svh"
// =====================================================================
// conversion sequencer for a successive approximation converter
module adct_seq (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] ctrl_reg_i,
  input wire logic start_i,
  input wire logic comp_hi_i,
  output logic sample_en_o,
  output logic hold_o,
  output logic [9:0] trial_code_o,
  output logic analog_off_o,
  output logic busy_o,
  output logic done_o,
  output logic [9:0] result_o
);
  import adct_pkg::*;

  // =====================================================================
  // overview
  // a conversion walks idle -> sample -> compare -> transfer -> idle.
  // units_r counts half cpu periods from the start of the sample phase,
  // so every phase end is a compare against a running sum of lengths.
  // the sample phase closes the input switch; compare and transfer keep
  // the sampled charge, so input moves after sampling cannot leak in.
  // the comparison phase is split into ten equal steps, one per result
  // bit, msb first; the comparator answer is used two clocks after the
  // trial code changes, which every step length comfortably covers.
  // the transfer phase soaks up what is left of the listed total, so the
  // whole conversion lasts exactly the table total for the chosen fields.
  // limitation: a start while busy or while powered off is dropped with
  // no indication; software must watch busy before asking again.
  // the timing fields are sampled on each start edge seen while idle, dropped or not, so a
  // rewrite of those fields mid-conversion changes nothing; the power-off bit is not held.

  adct_state_t state_r;
  adct_units_t units_r;
  adct_units_t smp_len;
  adct_units_t cmp_len;
  adct_units_t tot_len;
  logic [1:0] ctc_r;
  logic [1:0] stc_r;
  logic [9:0] sar_r;
  logic [3:0] bit_r;
  logic [11:0] step_len;
  logic [11:0] step_cnt_r;
  logic comp_s1_r;
  logic comp_s2_r;
  logic off_s1_r;
  logic off_s2_r;
  logic start_s1_r;
  logic start_s2_r;
  logic start_d_r;
  logic start_evt;
  logic [1:0] ctc_s1_r;
  logic [1:0] ctc_s2_r;
  logic [1:0] stc_s1_r;
  logic [1:0] stc_s2_r;

  // =====================================================================
  // input synchronisers, pins come from outside the clock domain
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      comp_s1_r <= 1'b0;
      comp_s2_r <= 1'b0;
      off_s1_r <= 1'b0;
      off_s2_r <= 1'b0;
      start_s1_r <= 1'b0;
      start_s2_r <= 1'b0;
      start_d_r <= 1'b0;
      ctc_s1_r <= 2'b00;
      ctc_s2_r <= 2'b00;
      stc_s1_r <= 2'b00;
      stc_s2_r <= 2'b00;
    end else begin
      comp_s1_r <= comp_hi_i;
      comp_s2_r <= comp_s1_r;
      off_s1_r <= ctrl_reg_i[`ADCT_POWER_OFF_BIT];
      off_s2_r <= off_s1_r;
      start_s1_r <= start_i;
      start_s2_r <= start_s1_r;
      start_d_r <= start_s2_r;
      // fields are multi-bit but written before start and then left alone,
      // so a plain two-stage capture is safe; the start edge is taken at the
      // second stage too, so fields written with start arrive in the same cycle
      ctc_s1_r <= ctrl_reg_i[`ADCT_CTC_LSB +: 2];
      ctc_s2_r <= ctc_s1_r;
      stc_s1_r <= ctrl_reg_i[`ADCT_STC_LSB +: 2];
      stc_s2_r <= stc_s1_r;
    end
  end

  assign start_evt = start_s2_r & ~start_d_r;

  // =====================================================================
  // timing lookup on the fields latched at start
  adct_timing_rom u_rom (
    .ctc_i(ctc_r),
    .stc_i(stc_r),
    .sample_o(smp_len),
    .compare_o(cmp_len),
    .total_o(tot_len)
  );

  // ten equal steps; step length is one tenth of the comparison phase
  assign step_len = cmp_len / 12'd10;

  // =====================================================================
  // field capture, taken only when idle so a rewrite mid-conversion is harmless
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctc_r <= 2'b00;
      stc_r <= 2'b00;
    end else if (state_r == ADCT_IDLE && start_evt) begin
      ctc_r <= ctc_s2_r;
      stc_r <= stc_s2_r;
    end
  end

  // =====================================================================
  // phase sequencing; units advance by two per clock
  // every listed length is even, so a phase of n units lasts n/2 clocks
  // and the next value is compared, which ends a phase on its last cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_r <= ADCT_IDLE;
      units_r <= 12'h000;
    end else begin
      unique case (state_r)
        ADCT_IDLE: begin
          units_r <= 12'h000;
          if (start_evt && !off_s2_r) begin
            state_r <= ADCT_SAMPLE;
          end
        end
        ADCT_SAMPLE: begin
          units_r <= units_r + 12'(`ADCT_UNITS_PER_CLK);
          if (units_r + 12'(`ADCT_UNITS_PER_CLK) >= smp_len) begin
            state_r <= ADCT_COMPARE;
          end
        end
        ADCT_COMPARE: begin
          units_r <= units_r + 12'(`ADCT_UNITS_PER_CLK);
          if (units_r + 12'(`ADCT_UNITS_PER_CLK) >= smp_len + cmp_len) begin
            state_r <= ADCT_XFER;
          end
        end
        ADCT_XFER: begin
          units_r <= units_r + 12'(`ADCT_UNITS_PER_CLK);
          if (units_r + 12'(`ADCT_UNITS_PER_CLK) >= tot_len) begin
            state_r <= ADCT_IDLE;
          end
        end
        default: state_r <= ADCT_IDLE;
      endcase
    end
  end

  // =====================================================================
  // successive approximation, msb first, one decision per step
  // the trial register is preset during sampling so the first comparator
  // answer is ready when the first step ends; bit index f marks all done
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sar_r <= 10'h000;
      bit_r <= 4'h0;
      step_cnt_r <= 12'h000;
    end else if (state_r == ADCT_SAMPLE) begin
      sar_r <= 10'h200;
      bit_r <= 4'h9;
      step_cnt_r <= 12'h000;
    end else if (state_r == ADCT_COMPARE) begin
      if (step_cnt_r + 12'(`ADCT_UNITS_PER_CLK) >= step_len) begin
        step_cnt_r <= 12'h000;
        if (bit_r != 4'hf) begin
          // comparator high means the trial exceeds the input: drop the bit
          if (comp_s2_r) begin
            sar_r[bit_r] <= 1'b0;
          end
          if (bit_r != 4'h0) begin
            sar_r[bit_r - 4'h1] <= 1'b1;
          end
          bit_r <= bit_r - 4'h1;
        end
      end else begin
        step_cnt_r <= step_cnt_r + 12'(`ADCT_UNITS_PER_CLK);
      end
    end
  end

  // =====================================================================
  // result load and completion pulse at the end of the transfer phase
  // the pulse shows in the first idle cycle, together with the new result
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      result_o <= 10'h000;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (state_r == ADCT_XFER && units_r + 12'(`ADCT_UNITS_PER_CLK) >= tot_len) begin
        result_o <= sar_r & `ADCT_RESULT_MAX;
        done_o <= 1'b1;
      end
    end
  end

  // =====================================================================
  // analog front-end controls
  assign sample_en_o = (state_r == ADCT_SAMPLE);
  assign hold_o = (state_r == ADCT_COMPARE) || (state_r == ADCT_XFER);
  assign trial_code_o = sar_r;
  assign analog_off_o = off_s2_r;
  assign busy_o = (state_r != ADCT_IDLE);
endmodule

// >>> hw/adct_timing_rom.sv
`timescale 1ns/1ps
`include "adct_cfg.svh"
// =====================================================================
// timing table lookup, lengths in half cpu periods
module adct_timing_rom (
  input wire logic [1:0] ctc_i,
  input wire logic [1:0] stc_i,
  output adct_pkg::adct_units_t sample_o,
  output adct_pkg::adct_units_t compare_o,
  output adct_pkg::adct_units_t total_o
);
  import adct_pkg::*;
  // comparison length is the listed one where it is consistent; the
  // transfer phase absorbs the difference so the total is always exact
  always_comb begin
    unique case ({ctc_i, stc_i})
      4'hc: begin sample_o = 12'd240; compare_o = 12'd480; total_o = 12'd772; end
      4'hd: begin sample_o = 12'd280; compare_o = 12'd560; total_o = 12'd868; end
      4'he: begin sample_o = 12'd400; compare_o = 12'd560; total_o = 12'd1060; end
      4'hf: begin sample_o = 12'd800; compare_o = 12'd560; total_o = 12'd1444; end
      4'h8: begin sample_o = 12'd480; compare_o = 12'd960; total_o = 12'd1540; end
      4'h9: begin sample_o = 12'd560; compare_o = 12'd1120; total_o = 12'd1732; end
      4'ha: begin sample_o = 12'd800; compare_o = 12'd1120; total_o = 12'd2116; end
      4'hb: begin sample_o = 12'd1600; compare_o = 12'd1120; total_o = 12'd2884; end
      // 00 and reserved 01 share one timing set
      4'h0, 4'h4: begin sample_o = 12'd120; compare_o = 12'd240; total_o = 12'd388; end
      4'h1, 4'h5: begin sample_o = 12'd140; compare_o = 12'd280; total_o = 12'd436; end
      4'h2, 4'h6: begin sample_o = 12'd200; compare_o = 12'd280; total_o = 12'd532; end
      default: begin sample_o = 12'd400; compare_o = 12'd260; total_o = 12'd724; end
    endcase
  end
endmodule

// >>> tb/adct_afe_model.sv
`timescale 1ns/1ps
// ==========
// analog front end: sample switch and comparator
module adct_afe_model (
  input wire logic clk_i,
  input wire logic sample_en_i,
  input wire logic analog_off_i,
  input wire logic [9:0] trial_code_i,
  input wire logic [9:0] vin_i,
  output logic comp_hi_o
);
  logic [9:0] held_r = 10'h000;
  logic junk_r = 1'b0;
  // track the input only while the switch is closed, then keep the charge
  always @(posedge clk_i) begin
    if (sample_en_i) held_r <= vin_i;
    junk_r <= ~junk_r;
  end
  // a powered-off comparator gives no usable answer, so it toggles
  assign comp_hi_o = analog_off_i ? junk_r : (trial_code_i > held_r);
endmodule

// >>> tb/adct_seq_chk.sv
`timescale 1ns/1ps
// ==========
// port checker for the sequencer
module adct_seq_chk (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] ctrl_reg_i,
  input wire logic sample_en_o,
  input wire logic hold_o,
  input wire logic analog_off_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [9:0] result_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  samp_hold_a: assert property (!(sample_en_o && hold_o)) else $error("sample and hold together");
  busy_phase_a: assert property (busy_o == (sample_en_o || hold_o)) else $error("busy not phase");
  start_samp_a: assert property ($rose(busy_o) |-> sample_en_o) else $error("no sample first");
  samp_cmp_a: assert property ($fell(sample_en_o) |-> hold_o) else $error("sample not to compare");
  hold_src_a: assert property ($rose(hold_o) |-> $past(sample_en_o)) else $error("hold without sample");
  done_end_a: assert property (done_o |-> !busy_o && $past(hold_o)) else $error("done misplaced");
  done_pulse_a: assert property (done_o |=> !done_o) else $error("done too long");
  result_upd_a: assert property (!$stable(result_o) |-> done_o) else $error("result moved");
  off_sync_a: assert property (analog_off_o == $past(ctrl_reg_i[5], 2)) else $error("power off lag");
  off_block_a: assert property (analog_off_o && !busy_o |=> !busy_o) else $error("start while off");
endmodule
bind adct_seq adct_seq_chk chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ctrl_reg_i(ctrl_reg_i),
  .sample_en_o(sample_en_o), .hold_o(hold_o), .analog_off_o(analog_off_o), .busy_o(busy_o),
  .done_o(done_o), .result_o(result_o));

// >>> tb/adct_seq_tb.sv
`timescale 1ns/1ps
// ==========
// bench for the conversion sequencer
module adct_seq_tb;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, start_i = 1'b0, comp_hi_i;
  logic [15:0] ctrl_reg_i = 16'h0000;
  logic [9:0] vin = 10'h000, trial_code_o, result_o;
  logic sample_en_o, hold_o, analog_off_o, busy_o, done_o;
  int n_errors = 0, n_compared = 0, cyc = 0;
  logic [11:0] s_tab [0:11] = '{120, 140, 200, 400, 240, 280, 400, 800, 480, 560, 800, 1600};
  logic [11:0] u_tab [0:11] = '{388, 436, 532, 724, 772, 868, 1060, 1444, 1540, 1732, 2116, 2884};
  always #12.5 clk_i = ~clk_i;
  adct_seq dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ctrl_reg_i(ctrl_reg_i), .start_i(start_i),
    .comp_hi_i(comp_hi_i), .sample_en_o(sample_en_o), .hold_o(hold_o), .trial_code_o(trial_code_o),
    .analog_off_o(analog_off_o), .busy_o(busy_o), .done_o(done_o), .result_o(result_o));
  adct_afe_model afe_u (.clk_i(clk_i), .sample_en_i(sample_en_o), .analog_off_i(analog_off_o),
    .trial_code_i(trial_code_o), .vin_i(vin), .comp_hi_o(comp_hi_i));
  task automatic stop_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one conversion; the input moves after sampling and a second start lands mid-run
  task automatic conv(input logic [1:0] c, input logic [1:0] s, input logic [9:0] v);
    int k, n, b;
    k = (c == 2'b11) ? 4 : (c == 2'b10) ? 8 : 0; // reserved 01 falls back to 00
    n = 0;
    b = 0;
    @(posedge clk_i);
    ctrl_reg_i <= {c, s, 12'h000};
    vin <= v;
    start_i <= 1'b1;
    for (int t = 0; t < 3000 && done_o !== 1'b1; t++) begin
      @(posedge clk_i);
      if (t == 4) start_i <= 1'b0;
      if (hold_o === 1'b1) vin <= ~v;
      if (t == s_tab[k + s] / 2 + 20) start_i <= 1'b1;
      #1;
      if (sample_en_o === 1'b1) n++;
      if (busy_o === 1'b1) b++;
    end
    chk({11'h000, done_o}, 12'h001);
    chk(12'(n), s_tab[k + s] / 2);
    chk(12'(b), u_tab[k + s] / 2);
    chk({2'b00, result_o}, {2'b00, v});
    @(posedge clk_i);
    start_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk({11'h000, busy_o}, 12'h000);
  endtask
  // power off: flag follows the bit and starts are ignored
  task automatic off_test;
    @(posedge clk_i);
    ctrl_reg_i <= 16'h0020;
    repeat (4) @(posedge clk_i);
    start_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk({10'h000, analog_off_o, busy_o}, 12'h002);
    ctrl_reg_i <= 16'h0000;
    start_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // bound on the whole run
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 12; i++) conv((i < 4) ? 2'b00 : (i < 8) ? 2'b11 : 2'b10, 2'(i), 10'(i * 93));
    conv(2'b00, 2'b11, 10'h3ff);
    conv(2'b01, 2'b10, 10'h155);
    off_test();
    conv(2'b11, 2'b00, 10'h2aa);
    stop_test();
  end
endmodule
